//--- common/stp_pkg.sv
// Constants, encodings and carrier types of the stepper ramp controller.
package stp_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RAMP_UNIT_MS = 100;
  localparam int unsigned LEVELS = 64;
  localparam logic [31:0] RAMP_UNIT_CYC = 32'(CLK_HZ / 1000 * RAMP_UNIT_MS);
  localparam logic [31:0] STEP_THR = 32'(CLK_HZ * LEVELS);
  localparam logic [31:0] SLICE_INC = 32'(LEVELS);
  localparam logic [27:0] SKIP_THR = 28'(LEVELS * LEVELS * 1000 / RAMP_UNIT_MS);
  localparam logic [6:0] LVL_MAX = 7'(LEVELS);
  localparam logic [6:0] LVL_MIN = 7'h01;
  // Register byte offsets.
  localparam logic [31:0] ADDR_CMD = 32'h0000_0000;
  localparam logic [31:0] ADDR_TARGET = 32'h0000_0004;
  localparam logic [31:0] ADDR_SPEED = 32'h0000_0008;
  localparam logic [31:0] ADDR_RAMP = 32'h0000_000C;
  localparam logic [31:0] ADDR_MODE = 32'h0000_0010;
  localparam logic [31:0] ADDR_POS = 32'h0000_0014;
  localparam logic [31:0] ADDR_MARK = 32'h0000_0018;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_001C;
  // Reset values of the persistent settings.
  localparam logic [12:0] SPEED_RST = 13'h0064;
  localparam logic [7:0] RAMP_RST = 8'h00;
  localparam logic [1:0] MON_ONE = 2'h1;
  localparam logic [1:0] MON_TWO = 2'h2;
  localparam logic [1:0] MON_BOTH = 2'h3;
  typedef enum logic [1:0] {
    MODE_FULL = 2'h0, MODE_HALF = 2'h1, MODE_WAVE = 2'h2
  } stp_mode_e;
  typedef enum logic [3:0] {
    OP_ABS = 4'h0, OP_REL = 4'h1, OP_ABS_STOP = 4'h2, OP_REL_STOP = 4'h3,
    OP_CW_UNTIL = 4'h4, OP_CCW_ZERO = 4'h5, OP_CW_MARK = 4'h6,
    OP_GO_MARK = 4'h7, OP_GO_HOME = 4'h8, OP_SETTINGS = 4'h9,
    OP_SET_POWER = 4'hA, OP_SET_HOME = 4'hB, OP_SET_MARK = 4'hC,
    OP_REM_ENTER = 4'hD, OP_REM_EXIT = 4'hE, OP_NONE = 4'hF
  } stp_op_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_SKIP = 4'h2, ST_RUN = 4'h4, ST_REMOTE = 4'h8
  } stp_state_e;
  typedef struct packed {
    logic mode_given;
    logic ramp_given;
    logic speed_given;
    logic [3:0] pad;
    stp_op_e op;
  } stp_cmd_s;
  typedef struct packed {
    logic [12:0] speed;
    logic [7:0] ramp;
    stp_mode_e mode;
  } stp_set_s;
  typedef struct packed {
    logic lim_two;
    logic lim_one;
    logic off_power;
    logic coil_on;
    logic remote;
    logic busy;
  } stp_stat_s;
  localparam stp_set_s SET_RST = '{SPEED_RST, RAMP_RST, MODE_FULL};
endpackage

//--- verilog/stp_ctrl.sv
// Stepper ramp controller with remote step/direction mode and AHB-Lite registers.
// Notes on behaviour
// [R1] - Enter-remote: input one steps, input two direction.
// [R2] - Remote: one step per step-input falling edge.
// [R3] - Direction high clockwise, low counter-clockwise.
// [R4] - Host holds direction stable around step fall.
// [R5] - Remote keeps drive mode; position tracks steps.
// [R6] - Entering remote energises the windings.
// [R7] - Exit-remote returns to commands, position kept.
// [R8] - After remote, idle power follows stored setting.
// [R9] - Status report gives position, speed, ramp.
// [R10] - Input report gives both limit input levels.
// [R11] - Move commands may carry speed, ramp, mode.
// [R12] - An empty parameter leaves that setting alone.
// [R13] - Changed settings persist for later commands.
// [R14] - Ramp uses 64 levels, each slice ramp/64.
// [R15] - Levels too slow for a slice are skipped.
// [R16] - Short moves start braking at the halfway point.
// [R17] - Limit stop with ramp decelerates from the event.
// [R18] - Zero or mark captured at the input event.
// [R19] - Limit stop without ramp halts at once.
// [R20] - Limit monitoring is level sensitive.
// [R21] - Idle power setting: 0 released, 1 energised.
// [R22] - Braking walks the levels down in reverse.
// [R23] - Position counts up clockwise, down otherwise.
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.
module stp_ctrl import stp_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Limit, step and direction pins.
  input wire logic limit_input_one,
  input wire logic limit_input_two,
  // Motor drive.
  output logic step_pulse,
  output logic step_cw,
  output logic coil_energise,
  output logic [1:0] drive_mode,
  output logic busy
);
  logic [1:0] lim_s1_q, lim_q, mon_q, mon_d;
  logic lim_prev_q, ap_wr_q, ap_wr_d, hreadyout_q, cmd_pend_q, cmd_pend_d;
  logic [31:0] ap_addr_q, ap_addr_d, hrdata_q, hrdata_d, acc_q, acc_d;
  logic [31:0] slice_q, slice_d, accel_q, accel_d, slice_lim, acc_sum, rem;
  stp_cmd_s cmd_q, cmd_d;
  logic signed [31:0] target_q, target_d;
  stp_set_s stage_q, stage_d, set_q, set_d;
  stp_state_e st_q, st_d;
  logic signed [31:0] pos_q, pos_d, mark_q, mark_d, tgt_q, tgt_d, dest;
  logic off_pwr_q, off_pwr_d, cont_q, cont_d, dir_q, dir_d;
  stp_op_e op_q, op_d;
  logic [6:0] level_q, level_d, lvl_min_q, lvl_min_d;
  logic decel_q, decel_d, forced_q, forced_d, step_q, step_d;
  logic coil_q, coil_d, busy_q, busy_d, mv, evt, cap, fire, tick, stepping;
  logic [19:0] rate;
  logic [27:0] skip_prod;
  stp_stat_s stat;
  // Two-flop synchronisers for the asynchronous pins.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lim_s1_q <= 2'h3;
      lim_q <= 2'h3;
      lim_prev_q <= 1'b1;
    end else begin
      lim_s1_q <= {limit_input_two, limit_input_one};
      lim_q <= lim_s1_q;
      lim_prev_q <= lim_q[0];
    end
  end
  assign stat = '{lim_q[1], lim_q[0], off_pwr_q, coil_q,
                  st_q == ST_REMOTE, busy_q};
  // Bus group: address phase capture, read mux, data phase writes.
  always_comb begin
    ap_wr_d = 1'b0;
    ap_addr_d = ap_addr_q;
    hrdata_d = hrdata_q;
    cmd_d = cmd_q;
    cmd_pend_d = 1'b0;
    target_d = target_q;
    stage_d = stage_q;
    if (ap_wr_q) begin
      case (ap_addr_q)
        ADDR_CMD: begin
          cmd_d = stp_cmd_s'(hwdata[10:0]);
          cmd_pend_d = 1'b1;
        end
        ADDR_TARGET: target_d = hwdata;
        ADDR_SPEED: stage_d.speed = hwdata[12:0];
        ADDR_RAMP: stage_d.ramp = hwdata[7:0];
        ADDR_MODE: stage_d.mode = stp_mode_e'(hwdata[1:0]);
        default: ;
      endcase
    end
    if (hready && hsel && htrans[1]) begin
      ap_wr_d = hwrite;
      ap_addr_d = haddr;
      if (!hwrite) begin
        case (haddr)
          ADDR_TARGET: hrdata_d = target_q;
          ADDR_SPEED: hrdata_d = 32'(set_q.speed); // [R9]
          ADDR_RAMP: hrdata_d = 32'(set_q.ramp); // [R9]
          ADDR_MODE: hrdata_d = 32'(set_q.mode);
          ADDR_POS: hrdata_d = pos_q; // [R9]
          ADDR_MARK: hrdata_d = mark_q;
          ADDR_STATUS: hrdata_d = 32'(stat); // [R10]
          default: hrdata_d = 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 32'h0000_0000;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      cmd_q <= stp_cmd_s'(11'h00F);
      cmd_pend_q <= 1'b0;
      target_q <= 32'sh0000_0000;
      stage_q <= SET_RST;
    end else begin
      ap_wr_q <= ap_wr_d;
      ap_addr_q <= ap_addr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      cmd_q <= cmd_d;
      cmd_pend_q <= cmd_pend_d;
      target_q <= target_d;
      stage_q <= stage_d;
    end
  end
  assign rate = 20'(set_q.speed) * 20'(level_q);
  assign skip_prod = 28'(rate) * 28'(set_q.ramp);
  assign slice_lim = 32'(set_q.ramp) * RAMP_UNIT_CYC;
  assign acc_sum = acc_q + 32'(rate);
  assign rem = 32'(dir_q ? tgt_q - pos_q : pos_q - tgt_q);
  assign evt = |(mon_q & ~lim_q); // [R20]
  assign cap = evt && !forced_q && (st_q == ST_SKIP || st_q == ST_RUN);
  assign fire = lim_prev_q && !lim_q[0];
  assign tick = set_q.ramp != 8'h00 && slice_q + SLICE_INC >= slice_lim;
  assign stepping = acc_sum >= STEP_THR;
  // Motion group: command take, ramp walk, stepping and remote mode.
  always_comb begin
    st_d = st_q;
    set_d = set_q;
    pos_d = pos_q;
    mark_d = mark_q;
    off_pwr_d = off_pwr_q;
    tgt_d = tgt_q;
    cont_d = cont_q;
    dir_d = dir_q;
    mon_d = mon_q;
    op_d = op_q;
    level_d = level_q;
    lvl_min_d = lvl_min_q;
    acc_d = acc_q;
    slice_d = slice_q;
    accel_d = accel_q;
    decel_d = decel_q;
    forced_d = forced_q;
    step_d = 1'b0;
    dest = pos_q;
    mv = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (cmd_pend_q) begin
          if (cmd_q.op <= OP_SETTINGS) begin
            if (cmd_q.speed_given) set_d.speed = stage_q.speed; // [R11] [R12]
            if (cmd_q.ramp_given) set_d.ramp = stage_q.ramp; // [R11] [R12]
            if (cmd_q.mode_given) set_d.mode = stage_q.mode; // [R11] [R13]
          end
          mv = 1'b1;
          cont_d = 1'b0;
          mon_d = 2'h0;
          op_d = cmd_q.op;
          case (cmd_q.op)
            OP_ABS: dest = target_q;
            OP_REL: dest = pos_q + target_q;
            OP_ABS_STOP: begin
              dest = target_q;
              mon_d = MON_BOTH;
            end
            OP_REL_STOP: begin
              dest = pos_q + target_q;
              mon_d = MON_BOTH;
            end
            OP_CW_UNTIL, OP_CW_MARK: begin
              cont_d = 1'b1;
              mon_d = MON_TWO;
            end
            OP_CCW_ZERO: begin
              cont_d = 1'b1;
              mon_d = MON_ONE;
            end
            OP_GO_MARK: dest = mark_q;
            OP_GO_HOME: dest = 32'sh0000_0000;
            OP_SET_POWER: begin
              off_pwr_d = target_q[0]; // [R21]
              mv = 1'b0;
            end
            OP_SET_HOME: begin
              pos_d = 32'sh0000_0000;
              mv = 1'b0;
            end
            OP_SET_MARK: begin
              mark_d = pos_q;
              mv = 1'b0;
            end
            OP_REM_ENTER: begin
              st_d = ST_REMOTE; // [R1]
              mv = 1'b0;
            end
            default: mv = 1'b0;
          endcase
          if (mv && (cont_d || dest != pos_q)) begin
            dir_d = cont_d ? cmd_q.op != OP_CCW_ZERO : dest > pos_q;
            tgt_d = dest;
            st_d = ST_SKIP;
            level_d = set_d.ramp == 8'h00 ? LVL_MAX : LVL_MIN;
            acc_d = 32'h0000_0000;
            slice_d = 32'h0000_0000;
            accel_d = 32'h0000_0000;
            decel_d = 1'b0;
            forced_d = 1'b0;
          end
        end
      end
      ST_SKIP: begin
        if (evt) begin
          st_d = ST_IDLE; // [R20]
        end else if (set_q.ramp != 8'h00 && level_q < LVL_MAX &&
                     skip_prod < SKIP_THR) begin
          level_d = level_q + LVL_MIN; // [R15]
        end else begin
          lvl_min_d = level_q; // [R15]
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        slice_d = tick ? 32'h0000_0000 : slice_q + SLICE_INC; // [R14]
        if (cap) begin
          forced_d = 1'b1;
          if (set_q.ramp == 8'h00) begin
            st_d = ST_IDLE; // [R19]
          end else begin
            decel_d = 1'b1; // [R17]
          end
        end else begin
          if (stepping) begin
            acc_d = acc_sum - STEP_THR;
            step_d = 1'b1;
            pos_d = dir_q ? pos_q + 32'sd1 : pos_q - 32'sd1; // [R23]
            if (!decel_q) accel_d = accel_q + 32'h0000_0001;
            if (!cont_q && rem == 32'h0000_0001) st_d = ST_IDLE;
          end else begin
            acc_d = acc_sum;
          end
          if (tick) begin
            if (decel_q) begin
              if (level_q > lvl_min_q) begin
                level_d = level_q - LVL_MIN; // [R22]
              end else if (forced_q) begin
                st_d = ST_IDLE;
              end
            end else if (level_q < LVL_MAX) begin
              level_d = level_q + LVL_MIN; // [R14]
            end
          end
          if (!cont_q && !forced_q && rem <= accel_q) decel_d = 1'b1; // [R16]
        end
      end
      ST_REMOTE: begin
        if (cmd_pend_q && cmd_q.op == OP_REM_EXIT) begin
          st_d = ST_IDLE; // [R7]
        end else if (fire) begin
          step_d = 1'b1; // [R2]
          dir_d = lim_q[1]; // [R3] [R4]
          pos_d = lim_q[1] ? pos_q + 32'sd1 : pos_q - 32'sd1; // [R5] [R23]
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (cap && op_q == OP_CCW_ZERO) pos_d = 32'sh0000_0000; // [R18]
    if (cap && op_q == OP_CW_MARK) mark_d = pos_q; // [R18]
    coil_d = st_d != ST_IDLE || off_pwr_d; // [R6] [R8]
    busy_d = st_d == ST_SKIP || st_d == ST_RUN;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      set_q <= SET_RST;
      pos_q <= 32'sh0000_0000;
      mark_q <= 32'sh0000_0000;
      off_pwr_q <= 1'b0;
      tgt_q <= 32'sh0000_0000;
      cont_q <= 1'b0;
      dir_q <= 1'b1;
      mon_q <= 2'h0;
      op_q <= OP_NONE;
      level_q <= LVL_MIN;
      lvl_min_q <= LVL_MIN;
      acc_q <= 32'h0000_0000;
      slice_q <= 32'h0000_0000;
      accel_q <= 32'h0000_0000;
      decel_q <= 1'b0;
      forced_q <= 1'b0;
      step_q <= 1'b0;
      coil_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      set_q <= set_d;
      pos_q <= pos_d;
      mark_q <= mark_d;
      off_pwr_q <= off_pwr_d;
      tgt_q <= tgt_d;
      cont_q <= cont_d;
      dir_q <= dir_d;
      mon_q <= mon_d;
      op_q <= op_d;
      level_q <= level_d;
      lvl_min_q <= lvl_min_d;
      acc_q <= acc_d;
      slice_q <= slice_d;
      accel_q <= accel_d;
      decel_q <= decel_d;
      forced_q <= forced_d;
      step_q <= step_d;
      coil_q <= coil_d;
      busy_q <= busy_d;
    end
  end
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign step_pulse = step_q;
  assign step_cw = dir_q;
  assign coil_energise = coil_q;
  assign drive_mode = set_q.mode;
  assign busy = busy_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence remote_fall;
    st_q == ST_REMOTE && fire && !(cmd_pend_q && cmd_q.op == OP_REM_EXIT);
  endsequence
  sequence limit_hit;
    st_q == ST_RUN && cap;
  endsequence
  remote_cw_a: assert property (remote_fall and lim_q[1] |=> // [R2] [R3]
    step_pulse && pos_q == $past(pos_q) + 32'sd1)
    else $error("remote clockwise step not taken");
  remote_ccw_a: assert property (remote_fall and !lim_q[1] |=> // [R23]
    step_pulse && pos_q == $past(pos_q) - 32'sd1)
    else $error("remote counter-clockwise step not taken");
  remote_power_a: assert property (st_q == ST_REMOTE |-> coil_energise) // [R6]
    else $error("windings off in remote mode");
  idle_power_a: assert property (st_q == ST_IDLE |-> // [R8] [R21]
    coil_energise == off_pwr_q)
    else $error("idle winding power differs from setting");
  remote_exit_a: assert property (st_q == ST_REMOTE && cmd_pend_q && // [R7]
    cmd_q.op == OP_REM_EXIT |=> st_q == ST_IDLE && $stable(pos_q))
    else $error("exit from remote lost position");
  level_range_a: assert property (level_q >= LVL_MIN && // [R14]
    level_q <= LVL_MAX)
    else $error("ramp level out of range");
  skip_walk_a: assert property (st_q == ST_SKIP && !evt && // [R15]
    set_q.ramp != 8'h00 && level_q < LVL_MAX && skip_prod < SKIP_THR
    |=> level_q == $past(level_q) + LVL_MIN)
    else $error("slow ramp level not skipped");
  halfway_a: assert property (st_q == ST_RUN && !cap && !cont_q && // [R16]
    !forced_q && rem <= accel_q |=> decel_q || st_q == ST_IDLE)
    else $error("braking not started at halfway point");
  ramp_stop_a: assert property (limit_hit and set_q.ramp != 8'h00 // [R17]
    |=> st_q == ST_RUN && decel_q && forced_q && !step_pulse)
    else $error("limit with ramp did not start braking");
  hard_stop_a: assert property (limit_hit and set_q.ramp == 8'h00 // [R19]
    |=> st_q == ST_IDLE && !busy)
    else $error("limit without ramp did not halt");
  home_capture_a: assert property (limit_hit and // [R18]
    op_q == OP_CCW_ZERO |=> pos_q == 32'sh0000_0000)
    else $error("home not captured at input event");
  settings_keep_a: assert property (!cmd_pend_q |=> $stable(set_q)) // [R13]
    else $error("settings changed without a command");
  start_stop_a: assert property (st_q == ST_SKIP && evt |=> // [R20]
    st_q == ST_IDLE ##1 !busy)
    else $error("move started on low limit did not stop");
endmodule

//--- verification/stp_host_model.sv
// Host-side model driving the step/direction and limit lines.
module stp_host_model (
  // Clock.
  input wire logic core_clk,
  // Lines toward the controller.
  output logic line_one,
  output logic line_two
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines rest at their pull-up level while the host lets go.
  initial begin
    line_one = 1'b1;
    line_two = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic set_lines(input logic one, input logic two);
    @(posedge core_clk);
    line_one <= one;
    line_two <= two;
  endtask

  // Direction is settled before each fall and kept well past it.
  task automatic pulses(input logic cw, input int n);
    set_lines(1'b1, cw);
    hold(4);
    repeat (n) begin
      line_one <= 1'b0;
      hold(6);
      line_one <= 1'b1;
      hold(6);
    end
    line_two <= 1'b1;
  endtask
endmodule

//--- verification/stp_ctrl_tb.sv
// Self-checking testbench of the stepper ramp controller.
module stp_ctrl_tb import stp_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, arst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, drive_mode;
  logic [2:0] hsize;
  logic line_one, line_two, step_pulse, step_cw, coil_energise, busy;
  int n_mismatch, total_checks, n_cw, n_ccw;

  stp_ctrl u_stp_ctrl (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .limit_input_one(line_one),
    .limit_input_two(line_two), .step_pulse(step_pulse),
    .step_cw(step_cw), .coil_energise(coil_energise),
    .drive_mode(drive_mode), .busy(busy));

  stp_host_model u_stp_host_model (.core_clk(core_clk),
    .line_one(line_one), .line_two(line_two));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Counts motor steps by direction as they leave the controller.
  always @(posedge core_clk) begin
    if (step_pulse === 1'b1 && step_cw === 1'b1) n_cw++;
    if (step_pulse === 1'b1 && step_cw === 1'b0) n_ccw++;
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] addr,
                     input logic [31:0] wdat, output logic [31:0] rdat);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= addr;
    hwrite <= wr;
    htrans <= 2'h2;
    hsize <= 3'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    hwdata <= wdat;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rdat = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, addr, v, d);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] addr,
                        input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, addr, 32'h0, d);
    chk(what, exp, d);
  endtask

  task automatic wait_idle();
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 40000 && busy !== 1'b0; i++) @(posedge core_clk);
    // Two more edges let the step counters take the final pulse.
    repeat (2) @(posedge core_clk);
    chk("busy", 32'h0, {31'h0, busy});
  endtask

  task automatic t_reset();
    chk("step_cw", 32'h1, {31'h0, step_cw});
    chk("coil", 32'h0, {31'h0, coil_energise});
    chk("drive_mode", 32'h0, {30'h0, drive_mode});
    rd_chk("speed", ADDR_SPEED, 32'h0000_0064);
    rd_chk("ramp", ADDR_RAMP, 32'h0000_0000);
    rd_chk("mode", ADDR_MODE, 32'h0000_0000);
    rd_chk("mark", ADDR_MARK, 32'h0000_0000);
    wr(ADDR_POS, 32'h0000_0005);
    wr(32'h0000_0020, 32'h0000_00FF);
    rd_chk("pos", ADDR_POS, 32'h0000_0000);
    rd_chk("unmapped", 32'h0000_0020, 32'h0000_0000);
    rd_chk("status", ADDR_STATUS, 32'h0000_0030);
  endtask

  task automatic t_settings();
    wr(ADDR_SPEED, 32'h0000_1388);
    wr(ADDR_MODE, 32'h0000_0001);
    wr(ADDR_TARGET, 32'h0000_0002);
    wr(ADDR_CMD, 32'h0000_0701);
    wait_idle();
    chk("cw steps", 32'h2, 32'(n_cw));
    rd_chk("pos", ADDR_POS, 32'h0000_0002);
    rd_chk("speed", ADDR_SPEED, 32'h0000_1388);
    chk("drive_mode", 32'h1, {30'h0, drive_mode});
    chk("coil", 32'h0, {31'h0, coil_energise});
    wr(ADDR_MODE, 32'h0000_0002);
    wr(ADDR_TARGET, 32'hFFFF_FFFF);
    wr(ADDR_CMD, 32'h0000_0001);
    wait_idle();
    chk("ccw steps", 32'h1, 32'(n_ccw));
    rd_chk("pos", ADDR_POS, 32'h0000_0001);
    rd_chk("mode", ADDR_MODE, 32'h0000_0001);
    rd_chk("speed", ADDR_SPEED, 32'h0000_1388);
    chk("drive_mode", 32'h1, {30'h0, drive_mode});
  endtask

  task automatic t_remote();
    wr(ADDR_CMD, 32'h0000_000D);
    u_stp_host_model.hold(4);
    chk("coil", 32'h1, {31'h0, coil_energise});
    rd_chk("status", ADDR_STATUS, 32'h0000_0036);
    u_stp_host_model.pulses(1'b1, 3);
    u_stp_host_model.pulses(1'b0, 1);
    u_stp_host_model.hold(8);
    chk("cw steps", 32'h5, 32'(n_cw));
    chk("ccw steps", 32'h2, 32'(n_ccw));
    rd_chk("pos", ADDR_POS, 32'h0000_0003);
    chk("drive_mode", 32'h1, {30'h0, drive_mode});
    wr(ADDR_CMD, 32'h0000_000E);
    u_stp_host_model.hold(4);
    chk("coil", 32'h0, {31'h0, coil_energise});
    rd_chk("pos", ADDR_POS, 32'h0000_0003);
    rd_chk("status", ADDR_STATUS, 32'h0000_0030);
    wr(ADDR_TARGET, 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_000A);
    u_stp_host_model.hold(4);
    chk("coil", 32'h1, {31'h0, coil_energise});
  endtask

  task automatic t_limit_stop();
    u_stp_host_model.set_lines(1'b1, 1'b0);
    u_stp_host_model.hold(4);
    rd_chk("status", ADDR_STATUS, 32'h0000_001C);
    wr(ADDR_TARGET, 32'h0000_0005);
    wr(ADDR_CMD, 32'h0000_0003);
    u_stp_host_model.hold(40);
    chk("busy", 32'h0, {31'h0, busy});
    chk("cw steps", 32'h5, 32'(n_cw));
    rd_chk("pos", ADDR_POS, 32'h0000_0003);
    u_stp_host_model.set_lines(1'b1, 1'b1);
  endtask

  task automatic t_zero_capture();
    wr(ADDR_CMD, 32'h0000_0005);
    for (int i = 0; i < 20000 && n_ccw == 2; i++) @(posedge core_clk);
    u_stp_host_model.set_lines(1'b0, 1'b1);
    wait_idle();
    chk("ccw steps", 32'h3, 32'(n_ccw));
    rd_chk("pos", ADDR_POS, 32'h0000_0000);
    rd_chk("status", ADDR_STATUS, 32'h0000_002C);
    u_stp_host_model.set_lines(1'b1, 1'b1);
    chk("coil", 32'h1, {31'h0, coil_energise});
  endtask

  task automatic t_marks();
    wr(ADDR_SPEED, 32'h0000_1FFF);
    wr(ADDR_TARGET, 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_0100);
    wait_idle();
    rd_chk("pos", ADDR_POS, 32'h0000_0001);
    rd_chk("speed", ADDR_SPEED, 32'h0000_1FFF);
    wr(ADDR_CMD, 32'h0000_000C);
    wr(ADDR_CMD, 32'h0000_000B);
    rd_chk("mark", ADDR_MARK, 32'h0000_0001);
    rd_chk("pos", ADDR_POS, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0007);
    wait_idle();
    rd_chk("pos", ADDR_POS, 32'h0000_0001);
    wr(ADDR_CMD, 32'h0000_0006);
    for (int i = 0; i < 20000 && n_cw == 7; i++) @(posedge core_clk);
    u_stp_host_model.set_lines(1'b1, 1'b0);
    wait_idle();
    chk("cw steps", 32'h8, 32'(n_cw));
    rd_chk("mark", ADDR_MARK, 32'h0000_0002);
    rd_chk("pos", ADDR_POS, 32'h0000_0002);
    u_stp_host_model.set_lines(1'b1, 1'b1);
    wr(ADDR_CMD, 32'h0000_0008);
    wait_idle();
    chk("ccw steps", 32'h5, 32'(n_ccw));
    rd_chk("pos", ADDR_POS, 32'h0000_0000);
    wr(ADDR_CMD, 32'h0000_0409);
    u_stp_host_model.hold(4);
    chk("drive_mode", 32'h2, {30'h0, drive_mode});
  endtask

  task automatic t_rerun_reset();
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk("coil", 32'h0, {31'h0, coil_energise});
    chk("drive_mode", 32'h0, {30'h0, drive_mode});
    rd_chk("speed", ADDR_SPEED, 32'h0000_0064);
    rd_chk("mark", ADDR_MARK, 32'h0000_0000);
    rd_chk("status", ADDR_STATUS, 32'h0000_0030);
  endtask

  initial begin
    #2_400_000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_settings();
    t_remote();
    t_limit_stop();
    t_zero_capture();
    t_marks();
    t_rerun_reset();
    tally_and_finish();
  end
endmodule
